// [shared/bsps_cfg.svh]
// bsps_cfg.svh: offsets, field positions, reset values and counts for the
// bus strobe and power-up sequencer.
// assumes a 40 MHz clock and a 32-bit classic wishbone register port.
`ifndef BSPS_CFG_SVH
`define BSPS_CFG_SVH

// register byte offsets
`define BSPS_A_CTRL 8'h00
`define BSPS_A_STAT 8'h04
`define BSPS_A_MODE 8'h08
`define BSPS_A_PC 8'h0C
`define BSPS_A_SP 8'h10
`define BSPS_A_PSW 8'h14

// control register fields
`define BSPS_CTRL_RSTI 0
`define BSPS_CTRL_CEN 1

// mode word fields
`define BSPS_MB_PCLK 0
`define BSPS_MB_STD 1
`define BSPS_MB_DLY 8
`define BSPS_MB_STAT 9
`define BSPS_MB_SMALL 10
`define BSPS_MB_NARROW 11
`define BSPS_MB_USER 12
`define BSPS_MB_START 13

// reset values and masks
`define BSPS_MODE_RST 16'hFFFF
`define BSPS_MODE_RSVD 16'h00FC
`define BSPS_PULL_MASK 16'hFF03
`define BSPS_SP_INIT 16'h00FE
`define BSPS_PSW_INIT 16'h00E0

// start addresses, selector 7 first
`define BSPS_START_TBL {16'hF400, 16'hF600, 16'h0000, 16'h1000, \
	16'h2000, 16'h4000, 16'h8000, 16'hC000}

// transaction codes on the select lines
`define BSPS_SEL_RW 2'h0
`define BSPS_SEL_REF 2'h1
`define BSPS_SEL_IACK 2'h2
`define BSPS_SEL_OTHER 2'h3

// timing
`define BSPS_CLK_MHZ 40
`define BSPS_FILL_NARROW 5'h14
`define BSPS_FILL_WIDE 5'h0A
`define BSPS_UC_STD 2'h2
`define BSPS_UC_LONG 2'h3
`define BSPS_LOAD_NS 400
`define BSPS_LOAD_CYC ((`BSPS_LOAD_NS * `BSPS_CLK_MHZ + 999) / 1000)

`endif

// [shared/bsps_pkg.sv]
// bsps_pkg: types of the bus strobe and power-up sequencer.
// assumes bsps_cfg.svh carries every number.
package bsps_pkg;

	// bus transaction kinds
	typedef enum logic [2:0] {
		BSPS_TX_RW = 3'h0,
		BSPS_TX_REF = 3'h1,
		BSPS_TX_IACK = 3'h2,
		BSPS_TX_DMA = 3'h3,
		BSPS_TX_INTERRUPT_POLL_CYCLE = 3'h4,
		BSPS_TX_NOP = 3'h5
	} bsps_txn_e;

	// bus phases, gray in listed order; pi to hold and hold to idle change two bits
	typedef enum logic [2:0] {
		BSPS_B_IDLE = 3'h0,
		BSPS_B_SETUP = 3'h1,
		BSPS_B_RAS = 3'h3,
		BSPS_B_CAS = 3'h2,
		BSPS_B_PI = 3'h6,
		BSPS_B_SLIP = 3'h7,
		BSPS_B_HOLD = 3'h5
	} bsps_bus_e;

	// power-up steps, gray along the path
	typedef enum logic [2:0] {
		BSPS_P_WAIT = 3'h0,
		BSPS_P_HIGH = 3'h1,
		BSPS_P_LOAD = 3'h3,
		BSPS_P_FILL = 3'h2,
		BSPS_P_REGS = 3'h6,
		BSPS_P_POLL = 3'h7,
		BSPS_P_RUN = 3'h5
	} bsps_pwr_e;

endpackage

// [verilog/bsps_sync.sv]
// bsps_sync: two-flop synchroniser for a group of pin inputs.
// assumes each bit is an independent level; no word coherence given.
`timescale 1ns/10ps
`default_nettype none
module bsps_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] meta;

	// first stage feeds only the second
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta <= INIT;
			q_o <= INIT;
		end else if (ce_i) begin
			meta <= d_i;
			q_o <= meta;
		end
	end
endmodule
`default_nettype wire

// [verilog/bsps_top.sv]
// bsps_top: bus strobes, wait slips, power-up sequence and clock output.
// assumes a core on the same clock issues transactions, wishbone registers.
// Behaviour
// - 16-bit mode byte write strobes on writes only
// - DMA releases both write pins to pull-ups
// - 8-bit mode read and write strobes, never both
// - delayed mode times strobes like column strobe
// - select lines carry the transaction code
// - one slip per wait assertion
// - wait ignored while row strobe is idle
// - slip only after row, column, priority edges
// - wait tied low gives one slip each
// - slips extend read/write, iack, DMA only
// - bus clear drives mode pull-ups on 15:8,1:0
// - power-up high aborts, control outputs unasserted
// - sequence starts on fall after seen rise
// - mode capture from clear and low until release
// - mode word from bus, bits 7:2 ignored
// - 20 or 10 refresh or idle cycles
// - load SP 376, PC start, PROCESSOR_STATUS_WORD 340
// - end with interrupt poll, then run
// - reset instruction: clear, mode, poll only
// - clock out half rate or microcycle pulse
// - mode bits select width, memory, size, tester; size and tester bits stored, unused
// - bits 15:13 pick start address
// - polarity of each mode bit
`timescale 1ns/10ps
`default_nettype none
`include "bsps_cfg.svh"
module bsps_top
	import bsps_pkg::*;
#(
	parameter int LOAD_CYC = `BSPS_LOAD_CYC
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// core transaction port
	input wire logic txn_req_i,
	input wire bsps_txn_e txn_type_i,
	input wire logic txn_wr_i,
	input wire logic txn_hb_i,
	input wire logic txn_lb_i,
	output logic txn_ack_o,
	output logic run_o,
	// pins
	input wire logic power_on_input_i,
	input wire logic wait_n_i,
	input wire logic [15:0] muxed_addr_data_lines_i,
	output logic [15:0] dal_pullup_en_o,
	output logic system_clear_out_n_o,
	output logic ras_n_o,
	output logic cas_n_o,
	output logic priority_sample_strobe_o,
	output logic high_byte_write_strobe_n_o,
	output logic high_byte_write_strobe_oe_o,
	output logic low_byte_write_strobe_n_o,
	output logic low_byte_write_strobe_oe_o,
	output logic [1:0] sel_o,
	output logic clock_output_pin_o
);
	localparam int LCW = $clog2(LOAD_CYC + 1);
	localparam logic [LCW-1:0] LOAD_LAST = LCW'(LOAD_CYC - 1);
	localparam logic [127:0] START_TBL = `BSPS_START_TBL;

	logic pup_s;
	logic wait_n_s;
	logic [15:0] dal_s;
	logic pup_q;
	logic [15:0] mode_config_word;
	logic [1:0] uc;
	logic uc_end;
	bsps_bus_e bus;
	bsps_pwr_e pwr;
	bsps_txn_e cur;
	logic cur_wr;
	logic cur_hb;
	logic cur_lb;
	logic wprev;
	logic [1:0] pend;
	logic slip_ok;
	logic ras_on;
	logic w_edge;
	logic done;
	logic go;
	bsps_txn_e go_type;
	logic [4:0] fill_cnt;
	logic [4:0] fill_tgt;
	logic [LCW-1:0] load_cnt;
	logic skip_init;
	logic [1:0] reg_step;
	logic [15:0] sp;
	logic [15:0] pc;
	logic [15:0] processor_status_word;
	logic rsti_req;
	logic core_en;
	logic wb_hit;
	logic [31:0] rd_mux;
	logic win;
	logic rw;

	// pins through two flops first
	bsps_sync #(
		.W(18),
		.INIT({1'b0, 1'b1, 16'hFFFF})
	) u_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.d_i({power_on_input_i, wait_n_i, muxed_addr_data_lines_i}),
		.q_o({pup_s, wait_n_s, dal_s})
	);

	// microcycle timing: long mode always four periods
	assign uc_end = (uc == (mode_config_word[`BSPS_MB_STD] ? `BSPS_UC_STD : `BSPS_UC_LONG));

	always_ff @(posedge clk_i) begin
		if (rst_i || (ce_i && pup_s)) begin
			uc <= 2'h0;
		end else if (ce_i) begin
			uc <= uc_end ? 2'h0 : 2'(uc + 2'h1);
		end
	end

	// transaction source: power-up steps first, core only when running
	always_comb begin
		go = 1'b0;
		go_type = BSPS_TX_NOP;
		case (pwr)
			BSPS_P_FILL: begin
				go = 1'b1;
				go_type = mode_config_word[`BSPS_MB_STAT] ? BSPS_TX_NOP : BSPS_TX_REF;
			end
			BSPS_P_POLL: begin
				go = 1'b1;
				go_type = BSPS_TX_INTERRUPT_POLL_CYCLE;
			end
			BSPS_P_RUN: begin
				go = txn_req_i && core_en && !rsti_req;
				go_type = txn_type_i;
			end
			default: begin
				go = 1'b0;
			end
		endcase
	end

	assign done = (bus == BSPS_B_HOLD) && uc_end;
	assign ras_on = (bus == BSPS_B_RAS) || (bus == BSPS_B_CAS) || (bus == BSPS_B_PI) || (bus == BSPS_B_SLIP);
	// refresh, poll and idle cycles never stretch
	assign slip_ok = (cur == BSPS_TX_RW) || (cur == BSPS_TX_IACK) || (cur == BSPS_TX_DMA);
	// an already-low wait at row strobe counts as an assertion
	assign w_edge = !wait_n_s && !wprev && ras_on && slip_ok;

	// bus phase machine, one phase per microcycle
	always_ff @(posedge clk_i) begin
		if (rst_i || (ce_i && pup_s)) begin
			bus <= BSPS_B_IDLE;
		end else if (ce_i && uc_end) begin
			case (bus)
				BSPS_B_IDLE: begin
					if (go) begin
						bus <= BSPS_B_SETUP;
					end
				end
				BSPS_B_SETUP: begin
					bus <= BSPS_B_RAS;
				end
				BSPS_B_RAS: begin
					bus <= BSPS_B_CAS;
				end
				BSPS_B_CAS: begin
					bus <= BSPS_B_PI;
				end
				BSPS_B_PI: begin
					// slips wait for all three leading edges
					bus <= (pend != 2'h0 || w_edge) ? BSPS_B_SLIP : BSPS_B_HOLD;
				end
				BSPS_B_SLIP: begin
					bus <= (pend > 2'h1 || w_edge) ? BSPS_B_SLIP : BSPS_B_HOLD;
				end
				BSPS_B_HOLD: begin
					bus <= BSPS_B_IDLE;
				end
				default: begin
					bus <= BSPS_B_IDLE;
				end
			endcase
		end
	end

	// latch the transaction at its start
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cur <= BSPS_TX_NOP;
			cur_wr <= 1'b0;
			cur_hb <= 1'b0;
			cur_lb <= 1'b0;
		end else if (ce_i && uc_end && bus == BSPS_B_IDLE && go) begin
			cur <= go_type;
			cur_wr <= (pwr == BSPS_P_RUN) && txn_wr_i;
			cur_hb <= txn_hb_i;
			cur_lb <= txn_lb_i;
		end
	end

	// pending slips: one per wait assertion, a set and a use in the same cycle cancel
	always_ff @(posedge clk_i) begin
		if (rst_i || (ce_i && (pup_s || bus == BSPS_B_IDLE))) begin
			pend <= 2'h0;
			wprev <= 1'b0;
		end else if (ce_i) begin
			wprev <= ras_on && !wait_n_s;
			if (w_edge && !(bus == BSPS_B_SLIP && uc_end)) begin
				pend <= (pend == 2'h3) ? pend : 2'(pend + 2'h1);
			end else if (!w_edge && bus == BSPS_B_SLIP && uc_end && pend != 2'h0) begin
				pend <= 2'(pend - 2'h1);
			end
		end
	end

	// power-up and reset-instruction sequencer
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pwr <= BSPS_P_WAIT;
		end else if (ce_i) begin
			if (pup_s) begin
				pwr <= BSPS_P_HIGH; // rise registered first
			end else begin
				case (pwr)
					BSPS_P_WAIT: begin
						pwr <= BSPS_P_WAIT;
					end
					BSPS_P_HIGH: begin
						pwr <= BSPS_P_LOAD; // clear on, input low
					end
					BSPS_P_LOAD: begin
						if (load_cnt == LOAD_LAST) begin
							pwr <= skip_init ? BSPS_P_POLL : BSPS_P_FILL;
						end
					end
					BSPS_P_FILL: begin
						if (done && fill_cnt == 5'(fill_tgt - 5'h1)) begin
							pwr <= BSPS_P_REGS;
						end
					end
					BSPS_P_REGS: begin
						if (reg_step == 2'h2) begin
							pwr <= BSPS_P_POLL;
						end
					end
					BSPS_P_POLL: begin
						if (done) begin
							pwr <= BSPS_P_RUN;
						end
					end
					BSPS_P_RUN: begin
						if (rsti_req && bus == BSPS_B_IDLE) begin
							pwr <= BSPS_P_LOAD;
						end
					end
					default: begin
						pwr <= BSPS_P_WAIT;
					end
				endcase
			end
		end
	end

	// sequence counters
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			load_cnt <= '0;
			fill_cnt <= 5'h0;
			reg_step <= 2'h0;
			skip_init <= 1'b0;
		end else if (ce_i) begin
			load_cnt <= (pwr == BSPS_P_LOAD) ? LCW'(load_cnt + 1'b1) : '0;
			reg_step <= (pwr == BSPS_P_REGS) ? 2'(reg_step + 2'h1) : 2'h0;
			if (pwr != BSPS_P_FILL) begin
				fill_cnt <= 5'h0;
			end else if (done) begin
				fill_cnt <= 5'(fill_cnt + 5'h1);
			end
			if (pup_s) begin
				skip_init <= 1'b0;
			end else if (pwr == BSPS_P_RUN && rsti_req && bus == BSPS_B_IDLE) begin
				skip_init <= 1'b1;
			end
		end
	end

	// cycle count follows bus width
	assign fill_tgt = mode_config_word[`BSPS_MB_NARROW] ? `BSPS_FILL_NARROW : `BSPS_FILL_WIDE;

	// mode capture while clear is driven; reserved bits forced to zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mode_config_word <= `BSPS_MODE_RST;
		end else if (ce_i && pwr == BSPS_P_LOAD && !pup_s) begin
			mode_config_word <= dal_s & ~`BSPS_MODE_RSVD;
		end
	end

	// register loads in order SP, PC, PROCESSOR_STATUS_WORD
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sp <= 16'h0000;
			pc <= 16'h0000;
			processor_status_word <= 16'h0000;
		end else if (ce_i && pwr == BSPS_P_REGS) begin
			case (reg_step)
				2'h0: sp <= `BSPS_SP_INIT;
				2'h1: pc <= START_TBL[mode_config_word[15:`BSPS_MB_START] * 16 +: 16];
				2'h2: processor_status_word <= `BSPS_PSW_INIT;
				default: sp <= sp;
			endcase
		end
	end

	// delayed mode follows the column strobe window
	assign win = mode_config_word[`BSPS_MB_DLY]
		? (bus == BSPS_B_CAS || bus == BSPS_B_PI || bus == BSPS_B_SLIP)
		: (bus != BSPS_B_IDLE);
	assign rw = win && cur == BSPS_TX_RW;

	// bus strobes and select lines, registered
	always_ff @(posedge clk_i) begin
		if (rst_i || (ce_i && pup_s)) begin
			ras_n_o <= 1'b1;
			cas_n_o <= 1'b1;
			priority_sample_strobe_o <= 1'b0;
			high_byte_write_strobe_n_o <= 1'b1;
			low_byte_write_strobe_n_o <= 1'b1;
			high_byte_write_strobe_oe_o <= 1'b1;
			low_byte_write_strobe_oe_o <= 1'b1;
			sel_o <= `BSPS_SEL_OTHER;
		end else if (ce_i) begin
			ras_n_o <= !(ras_on && (cur == BSPS_TX_RW || cur == BSPS_TX_REF
				|| cur == BSPS_TX_IACK || cur == BSPS_TX_DMA));
			cas_n_o <= !((bus == BSPS_B_CAS || bus == BSPS_B_PI || bus == BSPS_B_SLIP)
				&& (cur == BSPS_TX_RW || cur == BSPS_TX_DMA || cur == BSPS_TX_INTERRUPT_POLL_CYCLE));
			priority_sample_strobe_o <= (bus == BSPS_B_PI || bus == BSPS_B_SLIP)
				&& (cur == BSPS_TX_RW || cur == BSPS_TX_DMA || cur == BSPS_TX_INTERRUPT_POLL_CYCLE);
			if (mode_config_word[`BSPS_MB_NARROW]) begin
				high_byte_write_strobe_n_o <= !(rw && !cur_wr); // read strobe
				low_byte_write_strobe_n_o <= !(rw && cur_wr); // write_strobe_narrow
			end else begin
				high_byte_write_strobe_n_o <= !(rw && cur_wr && cur_hb);
				low_byte_write_strobe_n_o <= !(rw && cur_wr && cur_lb);
			end
			// DMA leaves the pins to the weak pull-ups
			high_byte_write_strobe_oe_o <= !(bus != BSPS_B_IDLE && cur == BSPS_TX_DMA);
			low_byte_write_strobe_oe_o <= !(bus != BSPS_B_IDLE && cur == BSPS_TX_DMA);
			if (bus == BSPS_B_IDLE) begin
				sel_o <= `BSPS_SEL_OTHER;
			end else begin
				case (cur)
					BSPS_TX_RW: sel_o <= `BSPS_SEL_RW;
					BSPS_TX_REF: sel_o <= `BSPS_SEL_REF;
					BSPS_TX_IACK: sel_o <= `BSPS_SEL_IACK;
					default: sel_o <= `BSPS_SEL_OTHER;
				endcase
			end
		end
	end

	// bus clear and pull-up enables
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			system_clear_out_n_o <= 1'b1;
			dal_pullup_en_o <= 16'h0000;
		end else if (ce_i) begin
			system_clear_out_n_o <= !(pup_s || pwr == BSPS_P_HIGH || pwr == BSPS_P_LOAD);
			dal_pullup_en_o <= (pup_s || pwr == BSPS_P_HIGH || pwr == BSPS_P_LOAD)
				? `BSPS_PULL_MASK : 16'h0000;
		end
	end

	// clock output: half rate, or one pulse per microcycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			clock_output_pin_o <= 1'b0;
		end else if (ce_i) begin
			if (mode_config_word[`BSPS_MB_PCLK]) begin
				clock_output_pin_o <= uc_end && !pup_s;
			end else begin
				clock_output_pin_o <= !clock_output_pin_o;
			end
		end
	end

	// core handshake, a one-cycle ack per core transaction
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			txn_ack_o <= 1'b0;
			run_o <= 1'b0;
		end else if (ce_i) begin
			txn_ack_o <= done && !pup_s && pwr == BSPS_P_RUN;
			run_o <= pwr == BSPS_P_RUN && !pup_s;
		end
	end

	// register port: one wait state, unmapped reads return zero
	assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;

	always_comb begin
		case (wb_adr_i)
			`BSPS_A_CTRL: rd_mux = {30'h0, core_en, rsti_req};
			`BSPS_A_STAT: rd_mux = {21'h0, pend, run_o, 1'b0, pwr, 1'b0, bus};
			`BSPS_A_MODE: rd_mux = {16'h0, mode_config_word};
			`BSPS_A_PC: rd_mux = {16'h0, pc};
			`BSPS_A_SP: rd_mux = {16'h0, sp};
			`BSPS_A_PSW: rd_mux = {16'h0, processor_status_word};
			default: rd_mux = 32'h0;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
		end else if (ce_i) begin
			wb_ack_o <= wb_hit;
			wb_dat_o <= (wb_hit && !wb_we_i) ? rd_mux : 32'h0;
		end
	end

	// control bits; a request taken at the same edge as a write stays set
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rsti_req <= 1'b0;
			core_en <= 1'b1;
		end else if (ce_i) begin
			if (wb_hit && wb_we_i && wb_adr_i == `BSPS_A_CTRL && wb_sel_i[0]) begin
				rsti_req <= rsti_req || wb_dat_i[`BSPS_CTRL_RSTI];
				core_en <= wb_dat_i[`BSPS_CTRL_CEN];
			end else if (pup_s || (pwr == BSPS_P_RUN && bus == BSPS_B_IDLE)) begin
				rsti_req <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

// [tb/bsps_props.sv]
// bsps_props: concurrent checks on the ports of bsps_top.
// assumes one clock domain and no request while ce_i is low.
`timescale 1ns/10ps
`default_nettype none
`include "bsps_cfg.svh"
module bsps_props (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic txn_ack_o,
	input wire logic run_o,
	input wire logic power_on_input_i,
	input wire logic [15:0] dal_pullup_en_o,
	input wire logic system_clear_out_n_o,
	input wire logic ras_n_o,
	input wire logic cas_n_o,
	input wire logic priority_sample_strobe_o,
	input wire logic high_byte_write_strobe_n_o,
	input wire logic high_byte_write_strobe_oe_o,
	input wire logic low_byte_write_strobe_n_o,
	input wire logic low_byte_write_strobe_oe_o,
	input wire logic [1:0] sel_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	// byte strobes belong to read/write transactions only
	a_hb_rw_only: assert property (
		high_byte_write_strobe_oe_o && !high_byte_write_strobe_n_o |-> sel_o == `BSPS_SEL_RW)
		else $error("high strobe outside read/write");
	a_lb_rw_only: assert property (
		low_byte_write_strobe_oe_o && !low_byte_write_strobe_n_o |-> sel_o == `BSPS_SEL_RW)
		else $error("low strobe outside read/write");
	// both pins released together, never one alone
	a_oe_pair: assert property (
		high_byte_write_strobe_oe_o == low_byte_write_strobe_oe_o)
		else $error("strobe enables differ");
	a_pull_clear: assert property (
		dal_pullup_en_o == (system_clear_out_n_o ? 16'h0000 : 16'hFF03))
		else $error("pull-up enables wrong for clear");
	// six cycles covers the two sync flops plus the reaction edge
	a_power_abort: assert property (
		power_on_input_i [*6] |-> ras_n_o && cas_n_o && !priority_sample_strobe_o
		&& high_byte_write_strobe_n_o && low_byte_write_strobe_n_o)
		else $error("strobes active while power-up held");
	a_power_clear: assert property (
		power_on_input_i [*6] |-> !system_clear_out_n_o)
		else $error("clear not asserted while power-up held");
	a_run_rise: assert property (
		$rose(run_o) |-> system_clear_out_n_o && $past(system_clear_out_n_o))
		else $error("run began inside clear");
	a_pi_in_cas: assert property (
		$rose(priority_sample_strobe_o) |-> !cas_n_o && $past(!cas_n_o))
		else $error("priority strobe before column strobe");
	a_wb_answer: assert property (
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("wishbone answer late");
	a_ack_pulse: assert property (
		wb_ack_o || txn_ack_o |=> !wb_ack_o && !txn_ack_o)
		else $error("acknowledge longer than one cycle");

	c_clear: cover property ($fell(system_clear_out_n_o));
	c_run: cover property ($rose(run_o));
	c_dma: cover property (!high_byte_write_strobe_oe_o && !ras_n_o);
endmodule
bind bsps_top bsps_props u_props (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .txn_ack_o, .run_o,
	.power_on_input_i, .dal_pullup_en_o, .system_clear_out_n_o, .ras_n_o, .cas_n_o, .priority_sample_strobe_o,
	.high_byte_write_strobe_n_o, .high_byte_write_strobe_oe_o, .low_byte_write_strobe_n_o,
	.low_byte_write_strobe_oe_o, .sel_o);
`default_nettype wire

// [tb/bsps_far.sv]
// bsps_far: memories, slow peripherals and mode drivers on the pins.
// assumes the bench sets the mode pattern and the slip requests.
`timescale 1ns/10ps
`default_nettype none
module bsps_far (
	input wire logic clk_i,
	input wire logic clear_n_i,
	input wire logic [15:0] pull_i,
	input wire logic ras_n_i,
	input wire logic [15:0] pat_i,
	input wire logic [1:0] slips_i,
	input wire logic tie_i,
	output logic [15:0] dal_o,
	output logic wait_n_o
);
	logic [2:0] cnt = 3'h0;
	logic ras_q = 1'b1;
	logic tog = 1'b0;

	// pattern held for the whole clear pulse; drivers pull only zeros low,
	// ones on 15:8 and 1:0 come from the design's pull-ups alone
	// released bus shows a moving pattern so stale data cannot pass
	always_comb begin
		if (!clear_n_i)
			dal_o = (pat_i & ~16'hFF03) | (pat_i & pull_i);
		else
			dal_o = {16{tog}} ^ 16'hA5C3;
	end

	// one low pulse per wanted slip, started at the row strobe edge
	always_ff @(posedge clk_i) begin
		tog <= ~tog;
		ras_q <= ras_n_i;
		if (ras_q && !ras_n_i)
			cnt <= {slips_i, 1'b0};
		else if (cnt != 3'h0)
			cnt <= cnt - 3'h1;
	end
	assign wait_n_o = tie_i ? 1'b0 : !(cnt != 3'h0 && !cnt[0]);
endmodule
`default_nettype wire

// [tb/test_bsps_top.sv]
// test_bsps_top: directed bench for the bus strobe and power-up sequencer.
// assumes bsps_far on the pins and wishbone access to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "bsps_cfg.svh"
module test_bsps_top;
	import bsps_pkg::*;
	logic clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1;
	logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'hF;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
	logic txn_req_i = 1'b0, txn_wr_i = 1'b0, txn_hb_i = 1'b0, txn_lb_i = 1'b0, txn_ack_o, run_o;
	bsps_txn_e txn_type_i = BSPS_TX_NOP;
	logic power_on_input_i = 1'b0, wait_n_i, system_clear_out_n_o, ras_n_o, cas_n_o, priority_sample_strobe_o;
	logic [15:0] muxed_addr_data_lines_i, dal_pullup_en_o, pat = 16'hFFFF;
	logic high_byte_write_strobe_n_o, high_byte_write_strobe_oe_o, clock_output_pin_o, wait_tie = 1'b0;
	logic low_byte_write_strobe_n_o, low_byte_write_strobe_oe_o;
	logic [1:0] sel_o, slips = 2'h0;
	int error_cnt = 0, n_checks = 0;

	always #12.5 clk_i = ~clk_i;

	// short mode load keeps the run brief
	bsps_top #(.LOAD_CYC(4)) uut (.clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
		.wb_dat_i, .wb_dat_o, .wb_ack_o, .txn_req_i, .txn_type_i, .txn_wr_i, .txn_hb_i, .txn_lb_i, .txn_ack_o,
		.run_o, .power_on_input_i, .wait_n_i, .muxed_addr_data_lines_i, .dal_pullup_en_o, .system_clear_out_n_o,
		.ras_n_o, .cas_n_o, .priority_sample_strobe_o, .high_byte_write_strobe_n_o, .high_byte_write_strobe_oe_o,
		.low_byte_write_strobe_n_o, .low_byte_write_strobe_oe_o, .sel_o, .clock_output_pin_o);
	bsps_far far (.clk_i(clk_i), .clear_n_i(system_clear_out_n_o), .pull_i(dal_pullup_en_o), .ras_n_i(ras_n_o),
		.pat_i(pat), .slips_i(slips), .tie_i(wait_tie), .dal_o(muxed_addr_data_lines_i), .wait_n_o(wait_n_i));

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic tmo(input string nm);
		error_cnt++;
		$display("Error %s expected done seen timeout", nm);
		report_and_stop();
	endtask

	// classic cycle: hold everything until ack is sampled high
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		int i;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		for (i = 0; i < 20 && wb_ack_o !== 1'b1; i++)
			@(posedge clk_i);
		if (wb_ack_o !== 1'b1)
			tmo("wishbone");
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
	endtask

	task automatic rdc(input logic [7:0] a, input logic [15:0] e, input string nm);
		logic [31:0] q;
		wb(1'b0, a, 32'h0, q);
		chk(nm, e, q[15:0]);
	endtask

	// power-up when pu is set, reset instruction otherwise; counts row strobes
	task automatic seq(input logic [15:0] p, input logic pu, input logic [15:0] er);
		int i;
		int n;
		logic prev;
		logic [31:0] q;
		pat <= p;
		if (pu) begin
			power_on_input_i <= 1'b1;
			repeat (8) @(posedge clk_i);
			chk("clear while high", 16'h0000, 16'(system_clear_out_n_o));
			chk("pull-ups", 16'hFF03, dal_pullup_en_o);
			power_on_input_i <= 1'b0;
		end else
			wb(1'b1, `BSPS_A_CTRL, 32'h3, q);
		for (i = 0; i < 100 && system_clear_out_n_o !== 1'b0; i++)
			@(posedge clk_i);
		if (system_clear_out_n_o !== 1'b0)
			tmo("clear");
		n = 0;
		prev = 1'b1;
		for (i = 0; i < 3000 && !(run_o === 1'b1 && system_clear_out_n_o === 1'b1); i++) begin
			@(posedge clk_i);
			if (prev === 1'b1 && ras_n_o === 1'b0)
				n++;
			prev = ras_n_o;
		end
		if (run_o !== 1'b1)
			tmo("run");
		chk("row strobes in sequence", er, 16'(n));
	endtask

	task automatic clock_output_pin_cnt(input logic [15:0] e);
		logic [15:0] n;
		n = 16'h0;
		repeat (30) begin
			@(posedge clk_i);
			n = n + 16'(clock_output_pin_o);
		end
		chk("clock out highs in 30", e, n);
	endtask

	// result packing: {high low, low low, released, sel, row-strobe cycles}
	task automatic txn(input bsps_txn_e t, input logic [2:0] whl, input logic [1:0] s, input logic tie,
		input logic [9:0] e);
		int i;
		logic [9:0] g;
		g = 10'h000;
		@(posedge clk_i);
		txn_req_i <= 1'b1;
		txn_type_i <= t;
		{txn_wr_i, txn_hb_i, txn_lb_i} <= whl;
		slips <= s;
		wait_tie <= tie;
		for (i = 0; i < 200 && txn_ack_o !== 1'b1; i++) begin
			@(posedge clk_i);
			if (ras_n_o === 1'b0) begin
				txn_req_i <= 1'b0;
				g[4:0] = g[4:0] + 5'h01;
				g[6:5] = sel_o;
			end
			if (high_byte_write_strobe_n_o === 1'b0 && high_byte_write_strobe_oe_o === 1'b1)
				g[9] = 1'b1;
			if (low_byte_write_strobe_n_o === 1'b0 && low_byte_write_strobe_oe_o === 1'b1)
				g[8] = 1'b1;
			if (high_byte_write_strobe_oe_o === 1'b0)
				g[7] = 1'b1;
		end
		if (txn_ack_o !== 1'b1)
			tmo("transaction");
		slips <= 2'h0;
		wait_tie <= 1'b0;
		chk("transaction", 16'(e), 16'(g));
	endtask

	initial begin
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		seq(16'h70FE, 1'b1, 16'h000A);
		rdc(`BSPS_A_MODE, 16'h7002, "mode");
		rdc(`BSPS_A_PC, 16'h2000, "pc");
		rdc(`BSPS_A_SP, 16'h00FE, "sp");
		rdc(`BSPS_A_PSW, 16'h00E0, "psw");
		rdc(8'h40, 16'h0000, "unmapped");
		clock_output_pin_cnt(16'h000F);
		// clock enable low must freeze the clock output
		ce_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		clock_output_pin_cnt(clock_output_pin_o ? 16'h001E : 16'h0000);
		ce_i <= 1'b1;
		$display("test power-up wide done");
		txn(BSPS_TX_RW, 3'b110, 2'h0, 1'b0, 10'h209);
		txn(BSPS_TX_RW, 3'b101, 2'h1, 1'b0, 10'h10C);
		txn(BSPS_TX_RW, 3'b011, 2'h2, 1'b0, 10'h00F);
		txn(BSPS_TX_IACK, 3'b000, 2'h0, 1'b1, 10'h04C);
		txn(BSPS_TX_DMA, 3'b111, 2'h0, 1'b0, 10'h0E9);
		$display("test wide transactions done");
		seq(16'h70FF, 1'b0, 16'h0000);
		rdc(`BSPS_A_MODE, 16'h7003, "mode reload");
		clock_output_pin_cnt(16'h000A);
		$display("test reset instruction done");
		seq(16'hE8FE, 1'b1, 16'h0014);
		rdc(`BSPS_A_MODE, 16'hE802, "mode narrow");
		rdc(`BSPS_A_PC, 16'hF400, "pc narrow");
		txn(BSPS_TX_RW, 3'b011, 2'h0, 1'b0, 10'h209);
		txn(BSPS_TX_RW, 3'b110, 2'h0, 1'b0, 10'h109);
		$display("test narrow bus done");
		seq(16'h7300, 1'b1, 16'h0000);
		rdc(`BSPS_A_MODE, 16'h7300, "mode static");
		txn(BSPS_TX_RW, 3'b110, 2'h0, 1'b0, 10'h20C);
		$display("test static long delayed done");
		report_and_stop();
	end
endmodule
`default_nettype wire
